/* File: baud_pkg.sv */
/*
 File: constants for the UART baud clock selection and framing flag block.
 Assumes: APB slave, 32-bit data, registers one aligned word each.
*/
// Function
// - Timer 2 overflow clocks selected directions
// - Transmit and receive may differ in source
// - Timer 2 rollover reloads sixteen-bit value
// - Timer 2 rate is fsys/(16*(65536-reload))
// - Prescaler and double speed ignored
// - Internal generator is 8-bit reload counter
// - Rollover loads baud reload value
// - Run bit 4 gates counting
// - Speed bit 1 picks divide-by-six or full
// - Rate scales with doubler, reload, speed
// - Bit 3 picks generator for transmit
// - Bit 2 picks generator for receive
// - Generator selects override Timer 2 selects
// - Bit 0 picks generator for mode 0
// - Missing stop bit sets framing flag
// - Serial control bit 7 muxes flag/mode
// - Only software clears the framing flag
// - Flag sets whatever the map select
// - Doubler is power control bit 7
package baud_pkg;
  localparam logic [11:0] BAUD_RELOAD_OFF = 12'h09A;
  localparam logic [11:0] BAUD_CTRL_OFF = 12'h09B;
  localparam logic [11:0] BAUD_RELOAD_ADDR = 12'h268;
  localparam logic [11:0] BAUD_CTRL_ADDR = 12'h26C;
  localparam logic [11:0] T2_CTRL_ADDR = 12'h300;
  localparam logic [11:0] T2_RELOAD_ADDR = 12'h304;
  localparam logic [11:0] SERIAL_CTRL_ADDR = 12'h308;
  localparam logic [11:0] POWER_CTRL_ADDR = 12'h30C;
  localparam int RUN_BIT = 4;
  localparam int TX_SEL_BIT = 3;
  localparam int RX_SEL_BIT = 2;
  localparam int FAST_BIT = 1;
  localparam int MODE0_SEL_BIT = 0;
  localparam int T2_RX_SEL_BIT = 5;
  localparam int T2_TX_SEL_BIT = 4;
  localparam int T2_RUN_BIT = 2;
  localparam int FRAME_BIT = 7;
  localparam int DOUBLER_BIT = 7;
  localparam int MAP_SEL_BIT = 6;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [2:0] SLOW_DIV_LAST = 3'h5;
  localparam logic [3:0] T2_BAUD_DIV_LAST = 4'hF;
endpackage

/* File: baud_clock_framing.sv */
/*
 File: baud generators, transmit/receive/mode 0 clock selection and framing flag.
 Assumes: APB master on pclk; Timer 1 overflow and stop-bit result come from
 same-clock logic; tick outputs feed the UART bit-timing dividers.
*/
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module baud_clock_framing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_overflow,
  input wire logic stop_bit_checked,
  input wire logic stop_bit_missing,
  input wire logic mode0_fixed_tick,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic mode0_tick,
  output logic generator_tick,
  output logic timer2_tick,
  output logic framing_error_flag
);
  logic [7:0] baud_reload_value_q;
  logic [4:0] baud_generator_control_q;
  logic [7:0] timer2_control_reg_q;
  logic [15:0] timer2_reload_q;
  logic [6:0] serial_control_low_q;
  logic uart_mode_bit_hi_q;
  logic [1:0] power_control_high_q;
  logic [2:0] slow_div_q;
  logic [3:0] t2_div_q;
  logic gen_roll;
  logic t2_roll;
  logic setup_ok;
  logic wr;
  logic rd_ok;
  logic [31:0] rd_d;
  logic gen_step;
  logic t2_step;
  logic t2_tx_use;
  logic t2_rx_use;
  logic err_set;
  logic map_select;
  logic wr_commit;
  logic hit_reload;
  logic hit_ctrl;
  logic hit_t2_ctrl;
  logic hit_t2_reload;
  logic hit_serial;
  logic hit_power;
  logic tx_tick_d;
  logic rx_tick_d;

  assign setup_ok = psel && !penable;
  assign wr = psel && penable && pwrite && pstrb[0] && clk_en;
  assign map_select = power_control_high_q[0];
  assign err_set = stop_bit_checked && stop_bit_missing;
  assign wr_commit = wr && pready;
  assign hit_reload = paddr == baud_pkg::BAUD_RELOAD_ADDR;
  assign hit_ctrl = paddr == baud_pkg::BAUD_CTRL_ADDR;
  assign hit_t2_ctrl = paddr == baud_pkg::T2_CTRL_ADDR;
  assign hit_t2_reload = paddr == baud_pkg::T2_RELOAD_ADDR;
  assign hit_serial = paddr == baud_pkg::SERIAL_CTRL_ADDR;
  assign hit_power = paddr == baud_pkg::POWER_CTRL_ADDR;

  // Decode and read mux; unmapped addresses answer with an error
  always_comb begin
    rd_ok = 1'b1;
    rd_d = 32'h0000_0000;
    unique case (paddr)
      baud_pkg::BAUD_RELOAD_ADDR: rd_d[7:0] = baud_reload_value_q;
      baud_pkg::BAUD_CTRL_ADDR: rd_d[4:0] = baud_generator_control_q;
      baud_pkg::T2_CTRL_ADDR: rd_d[7:0] = timer2_control_reg_q;
      baud_pkg::T2_RELOAD_ADDR: rd_d[15:0] = timer2_reload_q;
      baud_pkg::SERIAL_CTRL_ADDR: begin
        rd_d[6:0] = serial_control_low_q;
        rd_d[7] = map_select ? framing_error_flag : uart_mode_bit_hi_q;
      end
      baud_pkg::POWER_CTRL_ADDR: rd_d[7:6] = power_control_high_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // No wait cycle: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup_ok && !rd_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup_ok && !pwrite) begin
      prdata <= rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_reload_value_q <= baud_pkg::RELOAD_RESET;
    end else if (wr_commit && hit_reload) begin
      baud_reload_value_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_generator_control_q <= baud_pkg::CTRL_RESET;
    end else if (wr_commit && hit_ctrl) begin
      baud_generator_control_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_control_reg_q <= 8'h00;
    end else if (wr_commit && hit_t2_ctrl) begin
      timer2_control_reg_q <= pwdata[7:0];
    end
  end

  // Without lane 1 only the low reload byte changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_reload_q <= 16'h0000;
    end else if (wr_commit && hit_t2_reload) begin
      timer2_reload_q[7:0] <= pwdata[7:0];
      if (pstrb[1]) begin
        timer2_reload_q[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_low_q <= 7'h00;
    end else if (wr_commit && hit_serial) begin
      serial_control_low_q <= pwdata[6:0];
    end
  end

  // Mode bit only takes writes while bit 7 is mapped to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_mode_bit_hi_q <= 1'b0;
    end else if (wr_commit && hit_serial && !map_select) begin
      uart_mode_bit_hi_q <= pwdata[baud_pkg::FRAME_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_high_q <= 2'h0;
    end else if (wr_commit && hit_power) begin
      power_control_high_q <= pwdata[7:6];
    end
  end

  // Set beats clear; hardware never clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framing_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (err_set) begin
        framing_error_flag <= 1'b1;
      end else if (wr_commit && hit_serial && map_select) begin
        framing_error_flag <= pwdata[baud_pkg::FRAME_BIT];
      end
    end
  end

  // Slow mode steps once every six clocks
  assign gen_step = baud_generator_control_q[baud_pkg::RUN_BIT] &&
    (baud_generator_control_q[baud_pkg::FAST_BIT] || slow_div_q == baud_pkg::SLOW_DIV_LAST);
  reload_counter #(
    .WIDTH(8)
  ) gen_counter_u (
    .pclk(pclk),
    .presetn(presetn),
    .step(clk_en && gen_step),
    .reload(baud_reload_value_q),
    .roll(gen_roll)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_div_q <= 3'h0;
    end else if (clk_en) begin
      if (!baud_generator_control_q[baud_pkg::RUN_BIT] || slow_div_q == baud_pkg::SLOW_DIV_LAST) begin
        slow_div_q <= 3'h0;
      end else begin
        slow_div_q <= slow_div_q + 3'h1;
      end
    end
  end

  // Timer 2 counts undivided pclk; no prescaler path exists here
  assign t2_step = timer2_control_reg_q[baud_pkg::T2_RUN_BIT];

  reload_counter #(
    .WIDTH(16)
  ) t2_counter_u (
    .pclk(pclk),
    .presetn(presetn),
    .step(clk_en && t2_step),
    .reload(timer2_reload_q),
    .roll(t2_roll)
  );

  // Sixteen overflows per bit time give fsys/(16*(65536-reload))
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_div_q <= 4'h0;
    end else if (clk_en && t2_roll) begin
      t2_div_q <= t2_div_q + 4'h1;
    end
  end

  assign t2_tx_use = timer2_control_reg_q[baud_pkg::T2_TX_SEL_BIT];
  assign t2_rx_use = timer2_control_reg_q[baud_pkg::T2_RX_SEL_BIT];

  // Each direction picks its own source independently
  baud_source_mux tx_mux_u (
    .use_generator(baud_generator_control_q[baud_pkg::TX_SEL_BIT]),
    .use_timer2(t2_tx_use),
    .generator_roll(gen_roll),
    .timer2_roll(t2_roll),
    .timer1_roll(timer1_overflow),
    .tick_d(tx_tick_d)
  );

  baud_source_mux rx_mux_u (
    .use_generator(baud_generator_control_q[baud_pkg::RX_SEL_BIT]),
    .use_timer2(t2_rx_use),
    .generator_roll(gen_roll),
    .timer2_roll(t2_roll),
    .timer1_roll(timer1_overflow),
    .tick_d(rx_tick_d)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_baud_tick <= 1'b0;
    end else if (clk_en) begin
      tx_baud_tick <= tx_tick_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_baud_tick <= 1'b0;
    end else if (clk_en) begin
      rx_baud_tick <= rx_tick_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode0_tick <= 1'b0;
    end else if (clk_en) begin
      mode0_tick <= baud_generator_control_q[baud_pkg::MODE0_SEL_BIT] ? gen_roll
        : mode0_fixed_tick;
    end
  end

  // Raw rollover; doubler and 1/32 scaling sit in the UART's dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      generator_tick <= 1'b0;
    end else if (clk_en) begin
      generator_tick <= gen_roll;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer2_tick <= 1'b0;
    end else if (clk_en) begin
      timer2_tick <= t2_roll && t2_div_q == baud_pkg::T2_BAUD_DIV_LAST;
    end
  end
endmodule

module reload_counter #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic [WIDTH-1:0] reload,
  output logic roll
);
  logic [WIDTH-1:0] count_q;

  // Roll and reload share one edge, so no step is lost at the wrap
  assign roll = step && count_q == {WIDTH{1'b1}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (step) begin
      if (roll) begin
        count_q <= reload;
      end else begin
        count_q <= count_q + {{(WIDTH - 1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

module baud_source_mux (
  input wire logic use_generator,
  input wire logic use_timer2,
  input wire logic generator_roll,
  input wire logic timer2_roll,
  input wire logic timer1_roll,
  output logic tick_d
);
  // Generator select outranks the Timer 2 select
  always_comb begin
    if (use_generator) begin
      tick_d = generator_roll;
    end else if (use_timer2) begin
      tick_d = timer2_roll;
    end else begin
      tick_d = timer1_roll;
    end
  end
endmodule

/* File: baud_clock_framing_props.sv */
/* Port checker for baud_clock_framing; the bind follows the module.
   Assumes an APB write lands at the edge where pready is seen. */
`timescale 1ns/1ps
module baud_clock_framing_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic stop_bit_checked,
  input wire logic stop_bit_missing,
  input wire logic tx_baud_tick,
  input wire logic rx_baud_tick,
  input wire logic generator_tick,
  input wire logic framing_error_flag
);
  logic [4:0] sel_q;
  wire logic wr = psel && penable && pwrite;
  wire logic fe_wr = wr && paddr == baud_pkg::SERIAL_CTRL_ADDR;
  // Shadow control; selects judged only when stable over two edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 5'h00;
    end else if (wr && pready && paddr == baud_pkg::BAUD_CTRL_ADDR) begin
      sel_q <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_fe_set; stop_bit_checked && stop_bit_missing |=> framing_error_flag; endproperty
  a_fe_set: assert property (p_fe_set) else $error("flag not set");
  property p_fe_hold; framing_error_flag && !fe_wr |=> framing_error_flag; endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("flag lost");
  property p_fe_clr; $fell(framing_error_flag) |-> $past(fe_wr); endproperty
  a_fe_clr: assert property (p_fe_clr) else $error("flag fell unasked");
  property p_tx; sel_q[3] && $past(sel_q[3]) && generator_tick |-> tx_baud_tick; endproperty
  a_tx: assert property (p_tx) else $error("tx tick missing");
  property p_own; sel_q[3] && $past(sel_q[3]) && tx_baud_tick |-> generator_tick; endproperty
  a_own: assert property (p_own) else $error("tx tick foreign");
  property p_rx; sel_q[2] && $past(sel_q[2]) && generator_tick |-> rx_baud_tick; endproperty
  a_rx: assert property (p_rx) else $error("rx tick missing");
  property p_stop; !sel_q[4] && !$past(sel_q[4]) |-> !generator_tick; endproperty
  a_stop: assert property (p_stop) else $error("stopped tick");
  property p_txs; sel_q[3] && $past(sel_q[3]) && !sel_q[4] && !$past(sel_q[4]) |-> !tx_baud_tick;
  endproperty
  a_txs: assert property (p_txs) else $error("tx tick while stopped");
endmodule
bind baud_clock_framing baud_clock_framing_props props_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .stop_bit_checked(stop_bit_checked), .stop_bit_missing(stop_bit_missing),
  .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick), .generator_tick(generator_tick),
  .framing_error_flag(framing_error_flag));

/* File: serial_far_end.sv */
/* Far end model: Timer 1 overflow pulses and received-frame stop results.
   Assumes send_frame is called just after a rising pclk edge. */
`timescale 1ns/1ps
module serial_far_end #(parameter int T1_GAP = 10) (
  input wire logic pclk,
  input wire logic presetn,
  output logic t1_ovf,
  output logic checked,
  output logic missing
);
  logic [7:0] n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_q <= 8'h00;
    end else begin
      n_q <= (n_q == 8'(T1_GAP - 1)) ? 8'h00 : n_q + 8'h01;
    end
  end
  assign t1_ovf = n_q == 8'(T1_GAP - 1);
  initial begin
    checked = 1'h0;
    missing = 1'h1;
  end
  // Level flips outside the strobe, so a stale value is never trusted
  task send_frame(input logic absent);
    repeat (10) @(posedge pclk);
    checked <= 1'h1;
    missing <= absent;
    @(posedge pclk);
    checked <= 1'h0;
    missing <= !absent;
  endtask
endmodule

/* File: baud_clock_framing_tb.sv */
/* Self-checking bench for baud_clock_framing with the far end model.
   Assumes the port checker is bound; pstrb and clk_en stay high. */
`timescale 1ns/1ps
module baud_clock_framing_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, t1, chk, miss, fe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire [4:0] tk;
  int n_errors = 0;
  int num_checks = 0;
  baud_clock_framing dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer1_overflow(t1),
    .stop_bit_checked(chk), .stop_bit_missing(miss), .mode0_fixed_tick(1'h0),
    .tx_baud_tick(tk[0]), .rx_baud_tick(tk[1]), .mode0_tick(tk[2]),
    .generator_tick(tk[3]), .timer2_tick(tk[4]), .framing_error_flag(fe));
  serial_far_end far_u (.pclk(pclk), .presetn(presetn), .t1_ovf(t1), .checked(chk),
    .missing(miss));
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin @(posedge pclk); end while (pready !== 1'h1);
    rd = prdata; err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Third gap is measured; the first two may straddle a reconfiguration
  task period(input int i, input int lim, input int e, input string nm);
    int c;
    repeat (3) begin
      c = 0;
      do begin @(posedge pclk); c++; end while (tk[i] !== 1'h1 && c < lim);
    end
    check(nm, e, c);
  endtask
  task t_gen;
    apb(1'h0, baud_pkg::BAUD_CTRL_ADDR, 32'h0);
    check("ctrl reset", 32'h0, rd & 32'h1F);
    apb(1'h0, 12'hFF0, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    apb(1'h1, baud_pkg::BAUD_RELOAD_ADDR, 32'hFC);
    apb(1'h1, baud_pkg::BAUD_CTRL_ADDR, 32'h1E);
    period(3, 2000, 4, "gen fast");
    period(0, 2000, 4, "tx gen");
    period(1, 2000, 4, "rx gen");
    apb(1'h1, baud_pkg::BAUD_CTRL_ADDR, 32'h19);
    period(2, 2000, 24, "mode0 slow");
    period(1, 2000, 10, "rx t1");
    apb(1'h1, baud_pkg::BAUD_CTRL_ADDR, 32'h08);
    period(3, 300, 300, "stopped");
    period(0, 300, 300, "tx stopped");
    apb(1'h1, baud_pkg::BAUD_CTRL_ADDR, 32'h0);
  endtask
  task t_t2;
    apb(1'h1, baud_pkg::T2_RELOAD_ADDR, 32'hFFFE);
    apb(1'h1, baud_pkg::T2_CTRL_ADDR, 32'h24);
    period(4, 70000, 32, "t2 rate");
    period(1, 2000, 2, "rx t2");
    period(0, 2000, 10, "tx t1");
    apb(1'h1, baud_pkg::BAUD_CTRL_ADDR, 32'h16);
    period(1, 2000, 4, "gen over t2");
  endtask
  task t_fe;
    apb(1'h1, baud_pkg::SERIAL_CTRL_ADDR, 32'h0);
    far_u.send_frame(1'h1);
    apb(1'h0, baud_pkg::SERIAL_CTRL_ADDR, 32'h0);
    check("mode bit", 32'h0, rd & 32'h80);
    check("flag pin", 32'h1, {31'h0, fe});
    apb(1'h1, baud_pkg::POWER_CTRL_ADDR, 32'h40);
    apb(1'h0, baud_pkg::SERIAL_CTRL_ADDR, 32'h0);
    check("flag set", 32'h80, rd & 32'h80);
    far_u.send_frame(1'h0);
    apb(1'h1, baud_pkg::SERIAL_CTRL_ADDR, 32'h0);
    apb(1'h0, baud_pkg::SERIAL_CTRL_ADDR, 32'h0);
    check("flag clear", 32'h0, rd & 32'h80);
    check("flag pin clear", 32'h0, {31'h0, fe});
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0; pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_gen;
    t_t2;
    t_fe;
    give_verdict;
  end
  initial begin
    #720000;
    n_errors++;
    give_verdict;
  end
endmodule
